// ===== mmsd_regs.svh
`ifndef MMSD_REGS_SVH
`define MMSD_REGS_SVH

// ============================================================
// Data space offsets
`define MMSD_OFS_INDEX_FIRST        8'h80
`define MMSD_OFS_INDEX_SECOND       8'h81
`define MMSD_OFS_SHORT_FIRST        8'h82
`define MMSD_OFS_SHORT_SECOND       8'h83
`define MMSD_OFS_PORT_A_DATA        8'hC0
`define MMSD_OFS_PORT_B_DATA        8'hC1
`define MMSD_OFS_PORT_A_DIRECTION   8'hC4
`define MMSD_OFS_PORT_B_DIRECTION   8'hC5
`define MMSD_OFS_INTERRUPT_OPTIONS  8'hC8
`define MMSD_OFS_ROM_WINDOW_SELECT  8'hC9
`define MMSD_OFS_PORT_A_OPTION      8'hCC
`define MMSD_OFS_PORT_B_OPTION      8'hCD
`define MMSD_OFS_CONVERTER_RESULT   8'hD0
`define MMSD_OFS_CONVERTER_CONTROL  8'hD1
`define MMSD_OFS_TIMER_PRESCALER    8'hD2
`define MMSD_OFS_TIMER_DOWNCOUNTER  8'hD3
`define MMSD_OFS_TIMER_STATUS_CTRL  8'hD4
`define MMSD_OFS_WATCHDOG_COUNTER   8'hD8
`define MMSD_OFS_ACCUMULATOR        8'hFF

// ============================================================
// Regions
`define MMSD_RAM_BASE               8'h00
`define MMSD_RAM_BYTES              64
`define MMSD_WIN_BASE               8'h40
`define MMSD_WIN_LAST               8'h7F
`define MMSD_WIN_SEL_POS            0
`define MMSD_WIN_SEL_BITS           6
`define MMSD_STACK_DEPTH            6
`define MMSD_PC_BITS                12

// ============================================================
// Reset values and field layout
`define MMSD_RST_PORT               8'h00
`define MMSD_RST_CONVERTER_CONTROL  8'h40
`define MMSD_RST_TIMER_PRESCALER    8'h7F
`define MMSD_RST_TIMER_DOWNCOUNTER  8'hFF
`define MMSD_RST_TIMER_STATUS_CTRL  8'h00
`define MMSD_RST_WATCHDOG_COUNTER   8'hFE
`define MMSD_RST_UNDEFINED          8'h00
`define MMSD_CONV_RO_MASK           8'h80
`define MMSD_READ_FILL              8'h00

`endif

// ===== mmsd_pkg.sv
// ============================================================
// Types shared by the memory space decoder
package mmsd_pkg;

    // Read sequencer states, one-hot
    typedef enum logic [2:0] {
        MMSD_IDLE = 3'b001,
        MMSD_WIN  = 3'b010,
        MMSD_EXT  = 3'b100
    } mmsd_state_t;

endpackage

// ===== mmsd_return_stack.sv
`timescale 1ns/100ps
// ============================================================
// Return stack: shift structure, newest entry at index 0
module mmsd_return_stack
#(
    parameter int DEPTH = 6,
    parameter int WIDTH = 12
)
(
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] pushData,
    output logic      [WIDTH-1:0] top
);
    import mmsd_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] ent;
    } mmsd_stack_t;

    mmsd_stack_t stack_r;
    mmsd_stack_t stack_nxt;

    // ============================================================
    // Elaboration check
    generate
        if (DEPTH < 2 || WIDTH < 1)
        begin : g_bad
            $error("mmsd_return_stack: DEPTH must be at least 2");
        end
    endgenerate

    // ============================================================
    // Shift down on push, up on pop; the oldest level is lost when a
    // seventh call nests, as there is no overflow trap
    always_comb
    begin
        stack_nxt = stack_r;
        if (push)
        begin
            for (int i = DEPTH - 1; i > 0; i--)
            begin
                stack_nxt.ent[i] = stack_r.ent[i-1];
            end
            stack_nxt.ent[0] = pushData;
        end
        else if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                stack_nxt.ent[i] = stack_r.ent[i+1];
            end
            stack_nxt.ent[DEPTH-1] = '0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            stack_r <= '0;
        else
            stack_r <= stack_nxt;
    end

    assign top = stack_r.ent[0]; // Straight from the top flop
endmodule

// ===== mmsd_space_decoder.sv
`timescale 1ns/100ps
`include "mmsd_regs.svh"
// ============================================================
// Memory space decoder
// How it works
// - Program, data and stack spaces are decoded separately.
// - A 12-bit program counter addresses fetches over 4K of program memory.
// - Return stack holds six 12-bit return addresses for nesting.
// - Program memory constants are readable through a 64-byte data window.
// - With read-out protection set, external program reads are refused.
// - Index and short direct registers at 080h-083h, read/write, undefined reset.
// - Port data registers at 0C0h/0C1h, read/write, reset 00h.
// - Port direction registers at 0C4h/0C5h, read/write, reset 00h.
// - Port option registers at 0CCh/0CDh, read/write, reset 00h.
// - Interrupt option register at 0C8h, write-only, undefined reset.
// - Window select register at 0C9h, write-only, undefined reset.
// - Converter result at 0D0h, read-only, undefined reset.
// - Converter control at 0D1h, reset 40h, mixed read/write-only bits.
// - Timer prescaler at 0D2h, read/write, reset 7Fh.
// - Timer down-counter at 0D3h, read/write, reset 0FFh.
// - Timer status/control at 0D4h, read/write, reset 00h.
// - Data space holds RAM, core, port, peripheral and window registers.
// - Window spans 0040h-007Fh, block chosen by window select.
// - Port data reads return pins for inputs, register for outputs.
module mmsd_space_decoder
#(
    parameter int RAM_BYTES   = `MMSD_RAM_BYTES,
    parameter int STACK_DEPTH = `MMSD_STACK_DEPTH
)
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Data space access from the core
    input  wire logic [7:0]  dataAddr,
    input  wire logic        dataWrEn,
    input  wire logic        dataRdEn,
    input  wire logic [7:0]  dataWrData,
    output logic      [7:0]  dataRdData,
    output logic             dataRdValid,
    output logic             dataBusy,
    // Program counter control from the core
    input  wire logic        pcInc,
    input  wire logic        pcLoad,
    input  wire logic        pcCall,
    input  wire logic        pcReturn,
    input  wire logic [11:0] pcTarget,
    output logic      [11:0] programCounter,
    // Program memory data port, shared by window and external reads
    output logic      [11:0] romAddr,
    input  wire logic [7:0]  romData,
    // External read-out of program memory
    input  wire logic        protectOption,
    input  wire logic        extRdReq,
    input  wire logic [11:0] extRdAddr,
    output logic      [7:0]  extRdData,
    output logic             extRdValid,
    output logic             extRdDenied,
    // Port pins
    input  wire logic [7:0]  portAPins,
    input  wire logic [7:0]  portBPins,
    output logic      [7:0]  portAOut,
    output logic      [7:0]  portBOut,
    output logic      [7:0]  portAOe,
    output logic      [7:0]  portBOe,
    output logic      [7:0]  portAOpt,
    output logic      [7:0]  portBOpt,
    // Peripheral register contents
    input  wire logic [7:0]  convResult,
    input  wire logic [7:0]  convStatus,
    output logic      [7:0]  convControl,
    output logic      [7:0]  interruptOptions,
    output logic      [7:0]  timerPrescaler,
    output logic      [7:0]  timerDowncounter,
    output logic      [7:0]  timerStatusControl,
    output logic      [7:0]  watchdogCounter
);
    import mmsd_pkg::*;

    localparam int RAM_AW = (RAM_BYTES > 1) ? $clog2(RAM_BYTES) : 1;
    localparam int PCW    = `MMSD_PC_BITS;
    localparam int WSW    = `MMSD_WIN_SEL_BITS;

    // ============================================================
    // Elaboration check
    generate
        if (RAM_BYTES < 1 || RAM_BYTES > 64)
        begin : g_bad_ram
            $error("mmsd_space_decoder: RAM_BYTES must be 1 to 64");
        end
        if (STACK_DEPTH < 2)
        begin : g_bad_stack
            $error("mmsd_space_decoder: STACK_DEPTH must be at least 2");
        end
    endgenerate

    // ============================================================
    // All state of the block apart from the return stack, which u_stack holds
    typedef struct packed {
        mmsd_state_t                  state;
        logic [7:0]                   rdData;
        logic                         rdValid;
        logic                         busy;
        logic [PCW-1:0]               romAddr;
        logic                         extPending;
        logic [PCW-1:0]               extAddr;
        logic [7:0]                   extData;
        logic                         extValid;
        logic                         extDenied;
        logic [PCW-1:0]               pc;
        logic [RAM_BYTES-1:0][7:0]    ram;
        logic [3:0][7:0]              idx;
        logic [7:0]                   acc;
        logic [1:0][7:0]              pData;
        logic [1:0][7:0]              pDir;
        logic [1:0][7:0]              pOpt;
        logic [7:0]                   intOpt;
        logic [7:0]                   winSel;
        logic [7:0]                   convCtrl;
        logic [7:0]                   tPresc;
        logic [7:0]                   tDown;
        logic [7:0]                   tStat;
        logic [7:0]                   wdg;
    } mmsd_core_t;

    mmsd_core_t     st_r;
    mmsd_core_t     st_nxt;
    logic [PCW-1:0] stackTop;
    logic           winHit;
    logic           ramHit;
    logic [7:0]     regView;

    // ============================================================
    // Helpers
    // Output pins show the latch, input pins show the pad level
    function automatic logic [7:0] portView(input logic [7:0] data,
                                            input logic [7:0] dir,
                                            input logic [7:0] pins);
        portView = (data & dir) | (pins & ~dir);
    endfunction

    // Whether a data address lies inside a region
    function automatic logic inRange(input logic [7:0] a,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    // ============================================================
    // Stack space, its own storage and addressing
    mmsd_return_stack
    #(
        .DEPTH    (STACK_DEPTH),
        .WIDTH    (PCW)
    )
    u_stack
    (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .push     (pcCall && !pcReturn),
        .pop      (pcReturn),
        .pushData (st_r.pc),
        .top      (stackTop)
    );

    // ============================================================
    // Data space region hits
    assign winHit = inRange(dataAddr, `MMSD_WIN_BASE, `MMSD_WIN_LAST);
    assign ramHit = inRange(dataAddr, `MMSD_RAM_BASE,
                            8'(int'(`MMSD_RAM_BASE) + RAM_BYTES - 1));

    // Register read mux; write-only and unmapped read as a fill value
    always_comb
    begin
        regView = `MMSD_READ_FILL;
        if (ramHit)
            regView = st_r.ram[dataAddr[RAM_AW-1:0]];
        else
        begin
            case (dataAddr)
                `MMSD_OFS_INDEX_FIRST:       regView = st_r.idx[0];
                `MMSD_OFS_INDEX_SECOND:      regView = st_r.idx[1];
                `MMSD_OFS_SHORT_FIRST:       regView = st_r.idx[2];
                `MMSD_OFS_SHORT_SECOND:      regView = st_r.idx[3];
                `MMSD_OFS_PORT_A_DATA:
                    regView = portView(st_r.pData[0], st_r.pDir[0], portAPins);
                `MMSD_OFS_PORT_B_DATA:
                    regView = portView(st_r.pData[1], st_r.pDir[1], portBPins);
                `MMSD_OFS_PORT_A_DIRECTION:  regView = st_r.pDir[0];
                `MMSD_OFS_PORT_B_DIRECTION:  regView = st_r.pDir[1];
                `MMSD_OFS_PORT_A_OPTION:     regView = st_r.pOpt[0];
                `MMSD_OFS_PORT_B_OPTION:     regView = st_r.pOpt[1];
                `MMSD_OFS_CONVERTER_RESULT:  regView = convResult;
                `MMSD_OFS_CONVERTER_CONTROL:
                    regView = (convStatus & `MMSD_CONV_RO_MASK)
                            | (st_r.convCtrl & ~`MMSD_CONV_RO_MASK);
                `MMSD_OFS_TIMER_PRESCALER:   regView = st_r.tPresc;
                `MMSD_OFS_TIMER_DOWNCOUNTER: regView = st_r.tDown;
                `MMSD_OFS_TIMER_STATUS_CTRL: regView = st_r.tStat;
                `MMSD_OFS_WATCHDOG_COUNTER:  regView = st_r.wdg;
                `MMSD_OFS_ACCUMULATOR:       regView = st_r.acc;
                default:                     regView = `MMSD_READ_FILL;
            endcase
        end
    end

    // ============================================================
    // Next state: register writes, read sequencer, program counter
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.rdValid   = 1'b0;
        st_nxt.extValid  = 1'b0;
        st_nxt.extDenied = 1'b0;

        // Register writes; reserved, read-only and window writes are dropped
        if (dataWrEn)
        begin
            if (ramHit)
                st_nxt.ram[dataAddr[RAM_AW-1:0]] = dataWrData;
            else
            begin
                case (dataAddr)
                    `MMSD_OFS_INDEX_FIRST:       st_nxt.idx[0] = dataWrData;
                    `MMSD_OFS_INDEX_SECOND:      st_nxt.idx[1] = dataWrData;
                    `MMSD_OFS_SHORT_FIRST:       st_nxt.idx[2] = dataWrData;
                    `MMSD_OFS_SHORT_SECOND:      st_nxt.idx[3] = dataWrData;
                    `MMSD_OFS_PORT_A_DATA:       st_nxt.pData[0] = dataWrData;
                    `MMSD_OFS_PORT_B_DATA:       st_nxt.pData[1] = dataWrData;
                    `MMSD_OFS_PORT_A_DIRECTION:  st_nxt.pDir[0] = dataWrData;
                    `MMSD_OFS_PORT_B_DIRECTION:  st_nxt.pDir[1] = dataWrData;
                    `MMSD_OFS_PORT_A_OPTION:     st_nxt.pOpt[0] = dataWrData;
                    `MMSD_OFS_PORT_B_OPTION:     st_nxt.pOpt[1] = dataWrData;
                    `MMSD_OFS_INTERRUPT_OPTIONS: st_nxt.intOpt = dataWrData;
                    `MMSD_OFS_ROM_WINDOW_SELECT: st_nxt.winSel = dataWrData;
                    `MMSD_OFS_CONVERTER_CONTROL:
                        st_nxt.convCtrl = dataWrData & ~`MMSD_CONV_RO_MASK;
                    `MMSD_OFS_TIMER_PRESCALER:   st_nxt.tPresc = dataWrData;
                    `MMSD_OFS_TIMER_DOWNCOUNTER: st_nxt.tDown = dataWrData;
                    `MMSD_OFS_TIMER_STATUS_CTRL: st_nxt.tStat = dataWrData;
                    `MMSD_OFS_WATCHDOG_COUNTER:  st_nxt.wdg = dataWrData;
                    `MMSD_OFS_ACCUMULATOR:       st_nxt.acc = dataWrData;
                    default:                     st_nxt.acc = st_r.acc;
                endcase
            end
        end

        // Read sequencer; core reads win the memory port over read-out
        case (st_r.state)
            MMSD_IDLE:
            begin
                if (dataRdEn && winHit)
                begin
                    // Block number forms the upper address bits
                    st_nxt.romAddr = {st_r.winSel[`MMSD_WIN_SEL_POS +: WSW],
                                      dataAddr[5:0]};
                    st_nxt.state   = MMSD_WIN;
                    st_nxt.busy    = 1'b1;
                end
                else if (dataRdEn)
                begin
                    st_nxt.rdData  = regView;
                    st_nxt.rdValid = 1'b1;
                end
                else if (st_r.extPending)
                begin
                    st_nxt.romAddr    = st_r.extAddr;
                    st_nxt.extPending = 1'b0;
                    st_nxt.state      = MMSD_EXT;
                    st_nxt.busy       = 1'b1;
                end
            end
            MMSD_WIN:
            begin
                st_nxt.rdData  = romData;
                st_nxt.rdValid = 1'b1;
                st_nxt.busy    = 1'b0;
                st_nxt.state   = MMSD_IDLE;
            end
            MMSD_EXT:
            begin
                st_nxt.extData  = romData;
                st_nxt.extValid = 1'b1;
                st_nxt.busy     = 1'b0;
                st_nxt.state    = MMSD_IDLE;
            end
            default:
            begin
                st_nxt.state = MMSD_IDLE;
                st_nxt.busy  = 1'b0;
            end
        endcase

        // External read-out; one request outstanding at a time
        if (extRdReq && !st_r.extPending && st_r.state != MMSD_EXT)
        begin
            if (protectOption)
                st_nxt.extDenied = 1'b1;
            else
            begin
                st_nxt.extPending = 1'b1;
                st_nxt.extAddr    = extRdAddr;
            end
        end

        // Program space addressing, independent of the data port
        if (pcReturn)
            st_nxt.pc = stackTop;
        else if (pcLoad || pcCall)
            st_nxt.pc = pcTarget;
        else if (pcInc)
            st_nxt.pc = st_r.pc + 12'h001;
    end

    // ============================================================
    // State register; undefined-at-reset registers simply start at zero
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r          <= '0;
            st_r.state    <= MMSD_IDLE;
            st_r.pData    <= {2{`MMSD_RST_PORT}};
            st_r.pDir     <= {2{`MMSD_RST_PORT}};
            st_r.pOpt     <= {2{`MMSD_RST_PORT}};
            st_r.idx      <= {4{`MMSD_RST_UNDEFINED}};
            st_r.acc      <= `MMSD_RST_UNDEFINED;
            st_r.intOpt   <= `MMSD_RST_UNDEFINED;
            st_r.winSel   <= `MMSD_RST_UNDEFINED;
            st_r.convCtrl <= `MMSD_RST_CONVERTER_CONTROL;
            st_r.tPresc   <= `MMSD_RST_TIMER_PRESCALER;
            st_r.tDown    <= `MMSD_RST_TIMER_DOWNCOUNTER;
            st_r.tStat    <= `MMSD_RST_TIMER_STATUS_CTRL;
            st_r.wdg      <= `MMSD_RST_WATCHDOG_COUNTER;
        end
        else
            st_r <= st_nxt;
    end

    // ============================================================
    // Outputs, each straight from a flop
    assign dataRdData         = st_r.rdData;
    assign dataRdValid        = st_r.rdValid;
    assign dataBusy           = st_r.busy;
    assign programCounter     = st_r.pc;
    assign romAddr            = st_r.romAddr;
    assign extRdData          = st_r.extData;
    assign extRdValid         = st_r.extValid;
    assign extRdDenied        = st_r.extDenied;
    assign portAOut           = st_r.pData[0];
    assign portBOut           = st_r.pData[1];
    assign portAOe            = st_r.pDir[0];
    assign portBOe            = st_r.pDir[1];
    assign portAOpt           = st_r.pOpt[0];
    assign portBOpt           = st_r.pOpt[1];
    assign convControl        = st_r.convCtrl;
    assign interruptOptions   = st_r.intOpt;
    assign timerPrescaler     = st_r.tPresc;
    assign timerDowncounter   = st_r.tDown;
    assign timerStatusControl = st_r.tStat;
    assign watchdogCounter    = st_r.wdg;
endmodule

// ===== mmsd_rom_model.sv
`timescale 1ns/100ps
// ============================================================
// Program memory seen by the window and read-out paths
module mmsd_rom_model
(
    input  wire logic [11:0] romAddr,
    output logic      [7:0]  romData
);
    // Asynchronous image; high nibble folded in so blocks differ
    assign romData = romAddr[7:0] ^ {romAddr[11:8], 4'hA};
endmodule

// ===== mmsd_space_decoder_properties.sv
`timescale 1ns/100ps
// ============================================================
// Port-level checks of the decoder
module mmsd_space_decoder_properties
(
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic [7:0]  dataAddr,
    input wire logic        dataWrEn,
    input wire logic        dataRdEn,
    input wire logic [7:0]  dataWrData,
    input wire logic [7:0]  dataRdData,
    input wire logic        dataRdValid,
    input wire logic        dataBusy,
    input wire logic        pcCall,
    input wire logic        pcReturn,
    input wire logic [11:0] pcTarget,
    input wire logic [11:0] programCounter,
    input wire logic [7:0]  romData,
    input wire logic        protectOption,
    input wire logic [7:0]  extRdData,
    input wire logic        extRdValid,
    input wire logic        extRdDenied,
    input wire logic [7:0]  portAOut,
    input wire logic [7:0]  convControl,
    input wire logic [7:0]  timerPrescaler
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Window reads take one extra cycle through program memory
    sequence winRd;
        dataRdEn && !dataBusy && dataAddr[7:6] == 2'b01;
    endsequence
    win_read_a: assert property (winRd |=> dataBusy ##1 (dataRdValid && !dataBusy
        && dataRdData == $past(romData))) else $error("window read wrong");
    reg_read_a: assert property (dataRdEn && !dataBusy && dataAddr[7] |=> dataRdValid)
        else $error("register read late");
    valid_pulse_a: assert property (dataRdValid |=> !dataRdValid)
        else $error("read valid too long");
    pc_call_a: assert property (pcCall && !pcReturn |=> programCounter == $past(pcTarget))
        else $error("call target not loaded");
    deny_cause_a: assert property (extRdDenied |-> $past(protectOption))
        else $error("denied while unprotected");
    ext_data_a: assert property (extRdValid |-> !protectOption
        && extRdData == $past(romData)) else $error("read-out wrong");
    port_write_a: assert property (dataWrEn && dataAddr == 8'hC0
        |=> portAOut == $past(dataWrData)) else $error("port data not written");
    presc_write_a: assert property (dataWrEn && dataAddr == 8'hD2
        |=> timerPrescaler == $past(dataWrData)) else $error("prescaler not written");
    conv_bit_a: assert property (convControl[7] == 1'b0)
        else $error("control read-only bit stored");
    cover property (winRd ##2 dataRdValid);
    cover property (extRdValid);
    cover property (extRdDenied);
endmodule

bind mmsd_space_decoder mmsd_space_decoder_properties u_props (.ref_clk, .resetn, .dataAddr,
    .dataWrEn, .dataRdEn, .dataWrData, .dataRdData, .dataRdValid, .dataBusy, .pcCall,
    .pcReturn, .pcTarget, .programCounter, .romData, .protectOption, .extRdData,
    .extRdValid, .extRdDenied, .portAOut, .convControl, .timerPrescaler);

// ===== mmsd_space_decoder_tb.sv
`timescale 1ns/100ps
// ============================================================
// Self-checking bench for the memory space decoder
module mmsd_space_decoder_tb;
    logic ref_clk = 0, resetn = 0, dataWrEn = 0, dataRdEn = 0, pcInc = 0, pcLoad = 0;
    logic pcCall = 0, pcReturn = 0, protectOption = 0, extRdReq = 0;
    logic dataRdValid, dataBusy, extRdValid, extRdDenied;
    logic [7:0] dataAddr = 0, dataWrData = 0, portAPins = 0, portBPins = 0;
    logic [7:0] convResult = 0, convStatus = 0, dataRdData, romData, extRdData;
    logic [7:0] portAOut, portBOut, portAOe, portBOe, portAOpt, portBOpt, convControl;
    logic [7:0] interruptOptions, timerPrescaler, timerDowncounter, timerStatusControl;
    logic [7:0] watchdogCounter, v, d, s, lf = 8'h48;
    logic [11:0] pcTarget = 0, extRdAddr = 0, programCounter, romAddr, t;
    logic [7:0] mdl [logic [7:0]];
    logic [7:0] rsA[$] = '{8'hC0, 8'hC4, 8'hCC, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD8};
    logic [7:0] rsV[$] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h7F, 8'hFF, 8'h00, 8'hFE};
    logic [7:0] rwA[$] = '{8'h80, 8'h83, 8'hC5, 8'hCD, 8'hD2, 8'hD3, 8'hD4, 8'hFF, 8'h3F};
    logic [7:0] unA[$] = '{8'hC2, 8'hC8, 8'hC9, 8'hD5, 8'hFE};
    int n_errors = 0, num_checks = 0, cyc = 0, i;

    mmsd_space_decoder dut (.ref_clk, .resetn, .dataAddr, .dataWrEn, .dataRdEn, .dataWrData,
        .dataRdData, .dataRdValid, .dataBusy, .pcInc, .pcLoad, .pcCall, .pcReturn, .pcTarget,
        .programCounter, .romAddr, .romData, .protectOption, .extRdReq, .extRdAddr,
        .extRdData, .extRdValid, .extRdDenied, .portAPins, .portBPins, .portAOut, .portBOut,
        .portAOe, .portBOe, .portAOpt, .portBOpt, .convResult, .convStatus, .convControl,
        .interruptOptions, .timerPrescaler, .timerDowncounter, .timerStatusControl,
        .watchdogCounter);
    mmsd_rom_model rom (.romAddr, .romData);

    // ============================================================
    // Helpers
    initial forever #2 ref_clk = ~ref_clk;
    function automatic logic [7:0] nxt();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    function automatic logic [7:0] romv(logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'hA};
    endfunction
    task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] x);
        @(posedge ref_clk); #1 dataAddr = a; dataWrData = x; dataWrEn = 1;
        @(posedge ref_clk); #1 dataWrEn = 0;
    endtask
    // Read waits a bounded time for the valid pulse
    task automatic rd(logic [7:0] a, output logic [7:0] x);
        @(posedge ref_clk); #1 dataAddr = a; dataRdEn = 1;
        @(posedge ref_clk); #1 dataRdEn = 0;
        for (i = 0; i < 5 && dataRdValid !== 1'b1; i++) @(posedge ref_clk) #1;
        x = dataRdData;
    endtask
    task automatic pcmd(logic c, logic r, logic n, logic [11:0] tg);
        @(posedge ref_clk); #1 pcCall = c; pcReturn = r; pcInc = n; pcTarget = tg;
        @(posedge ref_clk); #1 {pcCall, pcReturn, pcInc} = 3'b000;
    endtask
    task automatic ext(logic p, output logic [1:0] res);
        @(posedge ref_clk); #1 protectOption = p; extRdAddr = {nxt(), nxt()} >> 4;
        extRdReq = 1; res = 0;
        @(posedge ref_clk); #1 extRdReq = 0; res = {extRdDenied, extRdValid};
        for (i = 0; i < 8 && res == 0; i++) @(posedge ref_clk) #1 res = {extRdDenied, extRdValid};
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard well above the roughly 150 cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    // ============================================================
    // Main sequence
    initial
    begin
        logic [1:0] res;
        repeat (3) @(posedge ref_clk);
        #1 resetn = 1;
        foreach (rsA[k]) begin rd(rsA[k], v); chk("reset", v, rsV[k]); end
        foreach (rwA[k]) begin mdl[rwA[k]] = nxt(); wr(rwA[k], mdl[rwA[k]]); end
        foreach (unA[k]) wr(unA[k], nxt());
        wr(8'hD0, nxt());
        foreach (rwA[k]) begin rd(rwA[k], v); chk("rw", v, mdl[rwA[k]]); end
        foreach (unA[k]) begin rd(unA[k], v); chk("blank", v, 8'h00); end
        chk("presc", timerPrescaler, mdl[8'hD2]);
        chk("portBOe", portBOe, mdl[8'hC5]);
        chk("tDown", timerDowncounter, mdl[8'hD3]);
        chk("tStat", timerStatusControl, mdl[8'hD4]);
        // Mixed direction so both read sources show
        s = nxt(); wr(8'hC4, s); d = nxt(); wr(8'hC0, d); portAPins = nxt();
        rd(8'hC0, v); chk("portA", v, (d & s) | (portAPins & ~s));
        chk("portAOut", portAOut, d);
        convResult = nxt(); convStatus = nxt(); d = nxt(); wr(8'hD1, d);
        rd(8'hD0, v); chk("result", v, convResult);
        rd(8'hD1, v); chk("control", v, {convStatus[7], d[6:0]});
        // Window block edges and six random offsets
        foreach (rsV[k])
        begin
            s = nxt() & 8'h3F; wr(8'hC9, s); d = (k == 0) ? 8'h00 : (k == 1) ? 8'h3F : nxt() & 8'h3F;
            rd(8'h40 + d, v); chk("window", v, romv({s[5:0], d[5:0]}));
        end
        ext(1'b0, res); chk("extOk", res, 2'b01);
        chk("extData", extRdData, romv(extRdAddr));
        ext(1'b1, res); chk("extDeny", res, 2'b10);
        // Count up, then two nested calls and their returns
        repeat (3) pcmd(0, 0, 1, 0);
        chk("pcInc", programCounter, 12'h003);
        t = {nxt(), nxt()} >> 4; pcmd(1, 0, 0, t); pcmd(1, 0, 0, 12'hFFF);
        chk("pcCall", programCounter, 12'hFFF);
        pcmd(0, 1, 0, 0); chk("ret1", programCounter, t);
        pcmd(0, 1, 0, 0); chk("ret2", programCounter, 12'h003);
        @(posedge ref_clk); #1 pcLoad = 1; pcInc = 1; pcTarget = 12'h5A5;
        @(posedge ref_clk); #1 {pcLoad, pcInc} = 2'b00; chk("pcLoad", programCounter, 12'h5A5);
        wrap_up();
    end
endmodule
